// ==== logic/cto_pkg.sv ====
// Package for the channel two display and output scaling block
package cto_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTO_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CTO_OFFS_ADDR = 8'h04;
    localparam logic [7:0] CTO_CMD_ADDR = 8'h08;
    localparam logic [7:0] CTO_STAT_ADDR = 8'h0C;
    localparam logic [7:0] CTO_OUT_ADDR = 8'h10;
    localparam logic [7:0] CTO_DISP_ADDR = 8'h14;
    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int CTO_SEL_LSB = 0;
    localparam int CTO_RATIO_LSB = 4;
    localparam int CTO_SRC_BIT = 8;
    localparam int CTO_OFFEN_BIT = 9;
    localparam int CTO_EXP_LSB = 12;
    localparam int CTO_TRIGST_BIT = 16;
    // Command register bits (write one to act)
    localparam int CTO_CMD_RATIO_BIT = 0;
    localparam int CTO_CMD_AOFF_BIT = 1;
    localparam int CTO_CMD_OFFTOG_BIT = 2;
    // ---------------------------------------------------------------
    // Scaling constants (values in units of 0.01 percent of full scale, phase in 0.01 degree)
    // ---------------------------------------------------------------
    localparam logic signed [17:0] CTO_OFFS_MAX = 18'sh02904; // 105.00 %
    localparam logic signed [17:0] CTO_OFFS_MIN = -18'sh02904; // -105.00 %
    localparam logic signed [17:0] CTO_FULL = 18'sh02710; // 100.00 %
    localparam logic signed [17:0] CTO_OUTPUT_OVERLOAD_INDICATOR_LIM = 18'sh02A94; // 109.00 %
    localparam logic signed [17:0] CTO_PHASE_FS = 18'sh04650; // 180.00 deg
    localparam logic signed [17:0] CTO_OUT_MAX = 18'sh02710; // 10 V
    localparam logic [31:0] CTO_CTRL_RST = 32'h0000_0000;
    // ---------------------------------------------------------------
    // Timing: output refresh rates
    // ---------------------------------------------------------------
    localparam longint CTO_CLK_HZ = 250000000;
    localparam longint CTO_FAST_HZ = 256000;
    localparam longint CTO_SLOW_HZ = 512;
    localparam int CTO_FAST_DIV = int'(CTO_CLK_HZ / CTO_FAST_HZ);
    localparam int CTO_SLOW_DIV = int'(CTO_CLK_HZ / CTO_SLOW_HZ);
    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        CTO_Q_Y = 3'b000,
        CTO_Q_PHASE = 3'b001,
        CTO_Q_YNOISE = 3'b010,
        CTO_Q_AUX3 = 3'b011,
        CTO_Q_AUX4 = 3'b100
    } cto_qty_t;
    typedef enum logic [1:0] {
        CTO_R_OFF = 2'b00,
        CTO_R_AUX3 = 2'b01,
        CTO_R_AUX4 = 2'b10
    } cto_ratio_t;
    typedef enum logic [1:0] {
        CTO_E_1 = 2'b00,
        CTO_E_10 = 2'b01,
        CTO_E_100 = 2'b10
    } cto_exp_t;
    // Measured inputs, all in hundredths of a percent of full scale / volts / degrees
    typedef struct packed {
        logic signed [17:0] y;
        logic signed [17:0] phase;
        logic signed [17:0] ynoise;
        logic signed [17:0] aux3;
        logic signed [17:0] aux4;
    } cto_meas_t;
    // Front panel indicators
    typedef struct packed {
        logic overload;
        logic auto_busy;
        logic trig;
        logic ratio;
        logic aux3_den;
        logic aux4_den;
        logic offset;
        logic expand;
    } cto_ind_t;
endpackage

// ==== logic/cto_top.sv ====
// Channel two display selection, ratio, offset, expand and output scaling
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Overview of operation
// - Display picks Y, phase, Y noise, aux3, aux4
// - Bar scale follows the selected quantity
// - Overload lit above 1.09 full scale
// - Auto indicator lit while auto function runs
// - Trigger flashes on edge with triggered storage
// - Ratio divides by aux3 or aux4
// - Ratio indicator lit while ratio active
// - Ratio key advances; none returns normal mode
// - Output source is display or Y after offset
// - Y source refreshes at 256 kHz
// - Display source refreshes at 512 Hz
// - Output is (signal minus offset) times expand
// - Expand holds one, ten or hundred
// - Expand indicator lit for ten or hundred
// - Offset, expand indicators follow displayed quantity
// - Offset applies to the Y display and its ratios, not to Y noise
// - Phase uses un-offset components
// - Expand never scales displayed Y
// - Offset toggle keeps stored percentage
// - Offset limited to plus minus 105.00
// - Offset independent of sensitivity
// - Auto offset zeroes present Y output when offset is on
// - Over-range expanded output flagged overloaded
// ---------------------------------------------------------------
module cto_top
    import cto_pkg::*;
#(
    parameter int FAST_DIV = CTO_FAST_DIV,
    parameter int SLOW_DIV = CTO_SLOW_DIV,
    parameter int TRIG_HOLD = 64
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire cto_meas_t i_meas,
    input wire logic i_auto_busy,
    input wire logic i_trig_in,
    output cto_ind_t o_ind,
    output logic signed [17:0] o_disp,
    output logic signed [17:0] o_dac,
    output logic o_dac_stb
);
    // Elaboration checks
    if (FAST_DIV < 2 || SLOW_DIV <= FAST_DIV || TRIG_HOLD < 1) begin : g_chk
        $error("cto_top: bad divider parameters");
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    cto_qty_t sel_reg;
    cto_ratio_t ratio_reg;
    cto_exp_t exp_reg;
    logic src_y_reg, offen_reg, trigst_reg, trig_last_reg;
    logic signed [17:0] offs_reg, offs_next;
    logic signed [17:0] disp_reg, dac_reg;
    logic output_overload_indicator_reg, stb_reg;
    logic [31:0] cnt_reg;
    logic [$clog2(TRIG_HOLD+1)-1:0] trig_cnt_reg;

    // Saturate a wide value into the 18-bit output range
    function automatic logic signed [17:0] sat18(input logic signed [31:0] v,
                                                 input logic signed [17:0] lim);
        if (v > 32'(lim)) begin
            sat18 = lim;
        end else if (v < -32'(lim)) begin
            sat18 = -lim;
        end else begin
            sat18 = v[17:0];
        end
    endfunction

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire acc = i_psel && i_penable && i_ce;
    wire wr = acc && i_pwrite;
    wire wr_ctrl = wr && i_paddr == CTO_CTRL_ADDR;
    wire wr_offs = wr && i_paddr == CTO_OFFS_ADDR;
    wire wr_cmd = wr && i_paddr == CTO_CMD_ADDR;
    wire mapped = i_paddr == CTO_CTRL_ADDR || i_paddr == CTO_OFFS_ADDR
        || i_paddr == CTO_CMD_ADDR || i_paddr == CTO_STAT_ADDR
        || i_paddr == CTO_OUT_ADDR || i_paddr == CTO_DISP_ADDR;
    wire ratio_key = wr_cmd && i_pwdata[CTO_CMD_RATIO_BIT];
    wire aoff_key = wr_cmd && i_pwdata[CTO_CMD_AOFF_BIT];
    wire offtog_key = wr_cmd && i_pwdata[CTO_CMD_OFFTOG_BIT];
    wire [2:0] wsel = i_pwdata[CTO_SEL_LSB +: 3];
    wire [1:0] wexp = i_pwdata[CTO_EXP_LSB +: 2];
    wire signed [17:0] woffs = i_pwdata[17:0];

    // ---------------------------------------------------------------
    // Selection and ratio
    // ---------------------------------------------------------------
    // Raw Y is offset-free; phase comes in un-offset from upstream
    wire signed [17:0] y_off = offen_reg ? 18'(i_meas.y - offs_reg) : i_meas.y;
    wire signed [17:0] phase_v = i_meas.phase;
    wire signed [17:0] numer = (sel_reg == CTO_Q_Y) ? y_off :
        (sel_reg == CTO_Q_PHASE) ? phase_v :
        (sel_reg == CTO_Q_YNOISE) ? i_meas.ynoise :
        (sel_reg == CTO_Q_AUX3) ? i_meas.aux3 : i_meas.aux4;
    wire ratio_on = ratio_reg != CTO_R_OFF;
    wire signed [17:0] denom = (ratio_reg == CTO_R_AUX3) ? i_meas.aux3 : i_meas.aux4;
    wire signed [31:0] rq_raw = (denom == 18'sh00000) ? 32'sh0000_0000 :
        (32'(numer) * 32'(CTO_FULL)) / 32'(denom);
    // Full scale of the bar graph per quantity, expressed in input units
    wire signed [17:0] fs = ratio_on ? CTO_FULL :
        (sel_reg == CTO_Q_PHASE) ? CTO_PHASE_FS : CTO_FULL;
    wire signed [31:0] val = ratio_on ? rq_raw : 32'(numer);
    // Displayed value is never expanded
    wire signed [17:0] disp_v = sat18(val, CTO_OFFS_MAX * 18'sh00002);
    // Normalised to percent of full scale
    wire signed [31:0] norm = (32'(disp_v) * 32'(CTO_FULL)) / 32'(fs);

    // ---------------------------------------------------------------
    // Output source, expand and overload
    // ---------------------------------------------------------------
    wire signed [31:0] src_v = src_y_reg ? 32'(y_off) : norm;
    wire signed [31:0] exp_mul = (exp_reg == CTO_E_10) ? 32'sh0000_000A :
        (exp_reg == CTO_E_100) ? 32'sh0000_0064 : 32'sh0000_0001;
    wire signed [31:0] out_w = src_v * exp_mul;
    wire output_overload_indicator_w = out_w > 32'(CTO_OUTPUT_OVERLOAD_INDICATOR_LIM) || out_w < -32'(CTO_OUTPUT_OVERLOAD_INDICATOR_LIM);
    wire signed [17:0] dac_w = sat18(out_w, CTO_OUT_MAX);
    wire [31:0] div_w = src_y_reg ? 32'(FAST_DIV - 1) : 32'(SLOW_DIV - 1);
    wire tick = cnt_reg >= div_w;
    // Auto offset target: present Y, clamped
    wire signed [17:0] ao_w = sat18(32'(i_meas.y), CTO_OFFS_MAX);
    wire woffs_ok = woffs <= CTO_OFFS_MAX && woffs >= CTO_OFFS_MIN;
    wire trig_edge = i_trig_in && !trig_last_reg;

    // Offset next value: auto offset over software write, clamped
    always_comb begin
        offs_next = offs_reg;
        if (aoff_key) begin
            offs_next = ao_w;
        end else if (wr_offs) begin
            offs_next = woffs_ok ? woffs : (woffs[17] ? CTO_OFFS_MIN : CTO_OFFS_MAX);
        end
    end

    // ---------------------------------------------------------------
    // Control state
    // ---------------------------------------------------------------
    // Settings written by software or keys
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sel_reg <= CTO_Q_Y;
            ratio_reg <= CTO_R_OFF;
            exp_reg <= CTO_E_1;
            src_y_reg <= 1'b0;
            offen_reg <= 1'b0;
            trigst_reg <= 1'b0;
            offs_reg <= 18'sh00000;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                sel_reg <= (wsel > 3'b100) ? CTO_Q_Y : cto_qty_t'(wsel);
                exp_reg <= (wexp == 2'b11) ? CTO_E_1 : cto_exp_t'(wexp);
                src_y_reg <= i_pwdata[CTO_SRC_BIT];
                trigst_reg <= i_pwdata[CTO_TRIGST_BIT];
            end
            if (ratio_key) begin
                // Off -> aux3 -> aux4 -> off
                ratio_reg <= (ratio_reg == CTO_R_OFF) ? CTO_R_AUX3 :
                    (ratio_reg == CTO_R_AUX3) ? CTO_R_AUX4 : CTO_R_OFF;
            end
            if (offtog_key) begin
                offen_reg <= !offen_reg;
            end
            offs_reg <= offs_next;
        end
    end

    // Output update cadence and sampling
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= 32'h0000_0000;
            dac_reg <= 18'sh00000;
            disp_reg <= 18'sh00000;
            output_overload_indicator_reg <= 1'b0;
            stb_reg <= 1'b0;
        end else if (i_ce) begin
            cnt_reg <= tick ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
            stb_reg <= tick;
            if (tick) begin
                dac_reg <= dac_w;
                output_overload_indicator_reg <= output_overload_indicator_w;
                disp_reg <= disp_v;
            end
        end
    end

    // Trigger flash stretcher
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_last_reg <= 1'b0;
            trig_cnt_reg <= '0;
        end else if (i_ce) begin
            trig_last_reg <= i_trig_in;
            if (trig_edge && trigst_reg) begin
                trig_cnt_reg <= ($clog2(TRIG_HOLD+1))'(TRIG_HOLD);
            end else if (trig_cnt_reg != '0) begin
                trig_cnt_reg <= trig_cnt_reg - 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Indicators and outputs
    // ---------------------------------------------------------------
    wire y_shown = sel_reg == CTO_Q_Y;
    assign o_ind.overload = output_overload_indicator_reg;
    assign o_ind.auto_busy = i_auto_busy;
    assign o_ind.trig = trig_cnt_reg != '0;
    assign o_ind.ratio = ratio_on;
    assign o_ind.aux3_den = ratio_reg == CTO_R_AUX3;
    assign o_ind.aux4_den = ratio_reg == CTO_R_AUX4;
    assign o_ind.offset = y_shown && offen_reg;
    assign o_ind.expand = y_shown && exp_reg != CTO_E_1;
    assign o_disp = disp_reg;
    assign o_dac = dac_reg;
    assign o_dac_stb = stb_reg;

    // Read mux
    wire [31:0] ctrl_rd = {15'h0000, trigst_reg, 2'h0, exp_reg, 2'h0, offen_reg,
        src_y_reg, 2'h0, ratio_reg, 1'b0, sel_reg};
    wire [31:0] stat_rd = {24'h00_0000, o_ind};
    assign o_prdata = !(i_psel && !i_pwrite) ? 32'h0000_0000 :
        (i_paddr == CTO_CTRL_ADDR) ? ctrl_rd :
        (i_paddr == CTO_OFFS_ADDR) ? 32'(offs_reg) :
        (i_paddr == CTO_STAT_ADDR) ? stat_rd :
        (i_paddr == CTO_OUT_ADDR) ? 32'(dac_reg) :
        (i_paddr == CTO_DISP_ADDR) ? 32'(disp_reg) : 32'h0000_0000;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    a_offset_range: assert property (offs_reg <= CTO_OFFS_MAX && offs_reg >= CTO_OFFS_MIN)
        else $error("offset out of range");
    a_ratio_cycle: assert property (i_ce && ratio_key && ratio_reg == CTO_R_AUX4 |=> ratio_reg == CTO_R_OFF)
        else $error("ratio did not return to off");
    a_ratio_led: assert property (o_ind.ratio == (o_ind.aux3_den || o_ind.aux4_den))
        else $error("ratio indicator mismatch");
    a_offtog_keep: assert property (i_ce && offtog_key && !aoff_key && !wr_offs |=> $stable(offs_reg))
        else $error("offset toggle changed offset");
    a_output_overload_indicator_sat: assert property (i_ce && tick && output_overload_indicator_w |=> o_ind.overload && (o_dac == CTO_OUT_MAX || o_dac == -CTO_OUT_MAX))
        else $error("overload not saturated");
    a_fast_rate: assert property (i_ce && src_y_reg && o_dac_stb && $stable(src_y_reg) |=> !o_dac_stb)
        else $error("strobe too fast");
    a_trig_flash: assert property (i_ce && trig_edge && !trigst_reg && trig_cnt_reg == '0 |=> !o_ind.trig)
        else $error("trigger flashed without triggered storage");
    a_expand_led: assert property (y_shown && exp_reg == CTO_E_1 |-> !o_ind.expand)
        else $error("expand indicator with unity expand");
    a_exp_legal: assert property (exp_reg != 2'b11)
        else $error("illegal expand");

    c_ratio_on: cover property (ratio_key ##1 o_ind.ratio);
    c_overload: cover property (o_ind.overload);
    c_autooff: cover property (aoff_key);
    c_trig: cover property (o_ind.trig);
endmodule // cto_top
`default_nettype wire

// ==== test/cto_panel_model.sv ====
// Output converter and trigger source model for the channel two block
`timescale 1ns/1ps
`default_nettype none
module cto_panel_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic signed [17:0] i_dac,
    input wire logic i_dac_stb,
    output logic o_trig
);
    int n_stb;
    int gap;
    int cyc;
    int last;
    logic signed [17:0] cap;
    // Converter latches each refreshed sample and times the spacing
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            n_stb <= 0;
            cyc <= 0;
            last <= 0;
            gap <= 0;
        end else begin
            cyc <= cyc + 1;
            if (i_dac_stb) begin
                cap <= i_dac;
                n_stb <= n_stb + 1;
                gap <= cyc - last;
                last <= cyc;
            end
        end
    end
    initial o_trig = 1'b0;
    // One clock wide edge on the rear trigger line
    task automatic pulse_trig();
        @(posedge i_clk);
        o_trig <= 1'b1;
        @(posedge i_clk);
        o_trig <= 1'b0;
    endtask
endmodule // cto_panel_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the channel two output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cto_pkg::*;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    localparam int FDIV = 4;
    localparam int SDIV = 16;
    localparam int THOLD = 4;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, abusy, trig, stb, er, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [17:0] disp, dac;
    cto_meas_t meas;
    cto_ind_t ind;
    int err_count, num_checks;
    cto_top #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV), .TRIG_HOLD(THOLD)) DUT (
        .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_meas(meas), .i_auto_busy(abusy),
        .i_trig_in(trig), .o_ind(ind), .o_disp(disp), .o_dac(dac), .o_dac_stb(stb));
    cto_panel_model m (.i_clk(clk), .i_rstn(rstn), .i_dac(dac), .i_dac_stb(stb),
        .o_trig(trig));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] sx(input logic [17:0] v);
        return 32'(signed'(v));
    endfunction
    // APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        if (n == 50) chk("pready", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_stb(input int k);
        int t;
        t = m.n_stb + k;
        for (int i = 0; i < 200 * k && m.n_stb < t; i++) @(posedge clk);
        #1;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, CTO_CTRL_ADDR, 32'h0);
        chk("ctrl reset", CTO_CTRL_RST, rd);
        apb(1'b0, CTO_OFFS_ADDR, 32'h0);
        chk("offset reset", 32'h0, sx(rd[17:0]));
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, 32'(er));
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_offs();
        int v[3] = '{20000, -20000, 10499};
        int x[3] = '{10500, -10500, 10499};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, CTO_OFFS_ADDR, 32'(v[i]));
            apb(1'b0, CTO_OFFS_ADDR, 32'h0);
            chk("offset", 32'(x[i]), sx(rd[17:0]));
        end
        apb(1'b1, CTO_CMD_ADDR, 32'h4);
        apb(1'b0, CTO_CTRL_ADDR, 32'h0);
        chk("offset on", 32'h1, 32'(rd[9]));
        apb(1'b0, CTO_OFFS_ADDR, 32'h0);
        chk("offset kept", 32'(10499), sx(rd[17:0]));
        meas.y <= 18'sd1234;
        apb(1'b1, CTO_CMD_ADDR, 32'h2);
        apb(1'b0, CTO_OFFS_ADDR, 32'h0);
        chk("auto offset", 32'(1234), sx(rd[17:0]));
        apb(1'b1, CTO_CTRL_ADDR, 32'h2100);
        wait_stb(3);
        chk("zeroed output", 32'h0, sx(dac));
    endtask
    // Y sourced output with offset enabled and one expand code
    task automatic t_out(input int y, input int off, input int e);
        int v;
        v = (y - off) * (e == 0 ? 1 : (e == 1 ? 10 : 100));
        apb(1'b1, CTO_OFFS_ADDR, 32'(off));
        apb(1'b1, CTO_CTRL_ADDR, 32'h100 | 32'(e << 12));
        meas.y <= 18'(y);
        wait_stb(3);
        chk("dac", 32'(v > 10000 ? 10000 : (v < -10000 ? -10000 : v)), sx(dac));
        chk("overload", 32'(v > 10900 || v < -10900), 32'(ind.overload));
        chk("expand ind", 32'(e != 0), 32'(ind.expand));
        if (off != 0) chk("offset ind", 32'h1, 32'(ind.offset));
    endtask
    task automatic t_ratio();
        int s;
        for (int i = 1; i <= 3; i++) begin
            s = i % 3;
            apb(1'b1, CTO_CMD_ADDR, 32'h1);
            apb(1'b0, CTO_CTRL_ADDR, 32'h0);
            chk("ratio state", 32'(s), 32'(rd[5:4]));
            chk("ratio ind", 32'(s != 0), 32'(ind.ratio));
            chk("den ind", 32'({s == 1, s == 2}), 32'({ind.aux3_den, ind.aux4_den}));
        end
    endtask
    task automatic t_disp();
        int ex[5] = '{2000, -4500, 100, 2500, -700};
        apb(1'b1, CTO_OFFS_ADDR, 32'h3E8);
        meas <= '{y: 18'sd3000, phase: -18'sd4500, ynoise: 18'sd100,
            aux3: 18'sd2500, aux4: -18'sd700};
        for (int q = 0; q < 5; q++) begin
            apb(1'b1, CTO_CTRL_ADDR, 32'h1000 | 32'(q));
            wait_stb(3);
            chk("disp", 32'(ex[q]), sx(disp));
            chk("offset ind", 32'(q == 0), 32'(ind.offset));
            chk("expand ind", 32'(q == 0), 32'(ind.expand));
        end
    endtask
    // Frozen clock enable ignores writes and strobes; mid-run reset clears
    task automatic t_ce();
        int n;
        apb(1'b1, CTO_OFFS_ADDR, 32'h64);
        @(posedge clk);
        ce <= 1'b0;
        n = m.n_stb;
        apb(1'b1, CTO_OFFS_ADDR, 32'h1F4);
        apb(1'b0, CTO_OFFS_ADDR, 32'h0);
        chk("frozen offset", 32'h64, sx(rd[17:0]));
        repeat (SDIV + 2) @(posedge clk);
        chk("frozen strobes", 32'(n), 32'(m.n_stb));
        ce <= 1'b1;
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, CTO_CTRL_ADDR, 32'h0);
        chk("ctrl after reset", CTO_CTRL_RST, rd);
        apb(1'b0, CTO_OFFS_ADDR, 32'h0);
        chk("offset after reset", 32'h0, sx(rd[17:0]));
    endtask
    task automatic t_rate();
        apb(1'b1, CTO_CTRL_ADDR, 32'h100);
        wait_stb(3);
        chk("fast gap", 32'(FDIV), 32'(m.gap));
        apb(1'b1, CTO_CTRL_ADDR, 32'h0);
        wait_stb(3);
        chk("slow gap", 32'(SDIV), 32'(m.gap));
    endtask
    task automatic t_flags();
        @(posedge clk);
        abusy <= 1'b1;
        @(posedge clk);
        #1;
        chk("auto ind on", 32'h1, 32'(ind.auto_busy));
        @(posedge clk);
        abusy <= 1'b0;
        @(posedge clk);
        #1;
        chk("auto ind off", 32'h0, 32'(ind.auto_busy));
        m.pulse_trig();
        repeat (3) @(posedge clk);
        #1;
        chk("trig untriggered", 32'h0, 32'(ind.trig));
        apb(1'b1, CTO_CTRL_ADDR, 32'h10000);
        m.pulse_trig();
        @(posedge clk);
        #1;
        chk("trig flash", 32'h1, 32'(ind.trig));
        repeat (THOLD + 2) @(posedge clk);
        #1;
        chk("trig ends", 32'h0, 32'(ind.trig));
    endtask
    // ---------------------------------------------------------------
    // Clock, sequence, watchdog and verdict
    // ---------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rstn, psel, penable, pwrite, abusy} = 5'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        meas = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_offs();
        t_out(500, 0, 2);
        t_out(1090, 0, 1);
        t_out(1091, 0, 1);
        t_out(-3000, 0, 0);
        t_out(-200, 0, 2);
        t_out(1500, 1000, 1);
        t_ratio();
        t_disp();
        t_rate();
        t_flags();
        t_ce();
        complete_run();
    end
    initial begin
        #200000;
        err_count++;
        $display("watchdog expired");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
